/* hdl/dnc_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dnc_params.svh"

module dnc_core
  import dnc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic list_run,
  input wire logic undefined_instr,
  input wire logic ext_nmi_b,
  output logic halt_irq_req,
  output logic nmi_req,
  output logic list_abort,
  output logic ovf_clear,
  output logic ext_hold,
  output dnc_region_t dsp_region
);

  dnc_state_t s_r;
  dnc_state_t s_nxt;
  logic ext_fall;

  function automatic dnc_region_t dnc_decode(input logic [31:0] addr);
    if (addr >= `DNC_RAM_BASE && addr < `DNC_RAM_END) begin
      dnc_decode = DNC_RGN_RAM;
    end else if (addr >= `DNC_DREG_BASE && addr < `DNC_DREG_END) begin
      dnc_decode = DNC_RGN_DREG;
    end else if (addr >= `DNC_CTRL_BASE && addr < `DNC_CTRL_END) begin
      dnc_decode = DNC_RGN_CTRL;
    end else begin
      dnc_decode = DNC_RGN_NONE;
    end
  endfunction

  function automatic logic ctrl_hit(input logic [31:0] addr,
                                    input logic [11:0] off);
    ctrl_hit = (dnc_decode(addr) == DNC_RGN_CTRL) && (addr[11:0] == off);
  endfunction

  dnc_fall_det u_nmi_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin_b(ext_nmi_b),
    .fall(ext_fall)
  );

  logic halt_evt;
  logic busy_err;
  logic acc;
  dnc_region_t rgn;
  logic [2:0] nmi_set;

  always_comb begin
    acc = reg_rd || reg_wr;
    rgn = dnc_decode(reg_addr);
    halt_evt = s_r.run_d && !list_run;
    // Control region stays reachable while the list runs
    busy_err = acc && list_run &&
               (rgn == DNC_RGN_RAM || rgn == DNC_RGN_DREG);
    nmi_set = 3'h0;
    nmi_set[`DNC_BIT_ERR] = busy_err;
    nmi_set[`DNC_BIT_UND] = undefined_instr;
    nmi_set[`DNC_BIT_EXT] = ext_fall;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.run_d = list_run;
    s_nxt.abort = 1'b0;
    s_nxt.ovf_clr = 1'b0;
    s_nxt.region = acc ? rgn : DNC_RGN_NONE;
    if (reg_rd) begin
      s_nxt.rdata = `DNC_RST_REG16;
      if (ctrl_hit(reg_addr, `DNC_OFF_LIST_STAT)) begin
        s_nxt.rdata[`DNC_BIT_RUN] = list_run;
      end else if (ctrl_hit(reg_addr, `DNC_OFF_EXT_HOLD)) begin
        s_nxt.rdata[`DNC_BIT_HOLD] = s_r.hold;
      end else if (ctrl_hit(reg_addr, `DNC_OFF_HALT_STAT)) begin
        s_nxt.rdata[`DNC_BIT_HALT] = s_r.halt;
        s_nxt.halt = 1'b0;
      end else if (ctrl_hit(reg_addr, `DNC_OFF_HALT_MASK)) begin
        s_nxt.rdata[`DNC_BIT_HALT] = s_r.mask;
      end else if (ctrl_hit(reg_addr, `DNC_OFF_NMI_ABORT)) begin
        s_nxt.rdata[2:0] = s_r.nmi;
        s_nxt.nmi = `DNC_RST_NMI;
      end
    end
    if (reg_wr) begin
      if (ctrl_hit(reg_addr, `DNC_OFF_EXT_HOLD)) begin
        s_nxt.hold = reg_wdata[`DNC_BIT_HOLD];
      end else if (ctrl_hit(reg_addr, `DNC_OFF_HALT_MASK)) begin
        s_nxt.mask = reg_wdata[`DNC_BIT_HALT];
      end else if (ctrl_hit(reg_addr, `DNC_OFF_NMI_ABORT)) begin
        s_nxt.abort = 1'b1;
        s_nxt.ovf_clr = 1'b1;
        s_nxt.hold = 1'b0;
        s_nxt.halt = 1'b0;
        s_nxt.mask = 1'b0;
      end
    end
    // Events win over any clear in the same cycle
    if (halt_evt) begin
      s_nxt.halt = 1'b1;
    end
    s_nxt.nmi = s_nxt.nmi | nmi_set;
    s_nxt.irq = s_nxt.halt && s_nxt.mask;
    s_nxt.nmi_req = |s_nxt.nmi;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.halt <= `DNC_RST_BIT;
      s_r.mask <= `DNC_RST_BIT;
      s_r.nmi <= `DNC_RST_NMI;
      s_r.hold <= `DNC_RST_BIT;
      s_r.run_d <= `DNC_RST_BIT;
      s_r.rdata <= `DNC_RST_REG16;
      s_r.irq <= `DNC_RST_BIT;
      s_r.nmi_req <= `DNC_RST_BIT;
      s_r.abort <= `DNC_RST_BIT;
      s_r.ovf_clr <= `DNC_RST_BIT;
      s_r.region <= DNC_RGN_NONE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign halt_irq_req = s_r.irq;
  assign nmi_req = s_r.nmi_req;
  assign list_abort = s_r.abort;
  assign ovf_clear = s_r.ovf_clr;
  assign ext_hold = s_r.hold;
  assign dsp_region = s_r.region;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  logic rd_halt;
  logic rd_nmi;
  logic wr_abort;
  assign rd_halt = reg_rd && ctrl_hit(reg_addr, `DNC_OFF_HALT_STAT);
  assign rd_nmi = reg_rd && ctrl_hit(reg_addr, `DNC_OFF_NMI_ABORT);
  assign wr_abort = reg_wr && ctrl_hit(reg_addr, `DNC_OFF_NMI_ABORT);

  sequence s_stop_seen;
    ce && s_r.run_d && !list_run;
  endsequence

  sequence s_abort_write;
    ce && wr_abort;
  endsequence

  a_halt_set: assert property (s_stop_seen |=> s_r.halt)
    else $error("halt flag not set after list stop");

  a_halt_rdclr: assert property (
    ce && rd_halt && !halt_evt |=> !s_r.halt && !halt_irq_req)
    else $error("halt status not cleared by read");

  a_halt_rddata: assert property (
    ce && rd_halt |=> reg_rdata[0] == $past(s_r.halt))
    else $error("halt status read returned wrong value");

  a_irq_gate: assert property (
    halt_irq_req |-> s_r.halt && s_r.mask)
    else $error("interrupt request without flag and mask");

  a_irq_raise: assert property (
    s_stop_seen ##0 (s_r.mask && !wr_abort &&
      !(reg_wr && ctrl_hit(reg_addr, `DNC_OFF_HALT_MASK))) |=> halt_irq_req)
    else $error("unmasked halt did not raise interrupt");

  a_abort_clr: assert property (
    s_abort_write ##0 !halt_evt |=>
      list_abort && ovf_clear && !ext_hold && !s_r.mask && !s_r.halt
      ##1 (!$past(ce) || $past(wr_abort) || !list_abort))
    else $error("abort write did not clear state as one pulse");

  a_mask_write: assert property (
    ce && reg_wr && ctrl_hit(reg_addr, `DNC_OFF_HALT_MASK) |=>
      s_r.mask == $past(reg_wdata[0]))
    else $error("halt mask write not stored");

  a_busy_err: assert property (
    ce && busy_err |=> s_r.nmi[`DNC_BIT_ERR] && nmi_req)
    else $error("busy access did not set error bit");

  a_ctrl_exempt: assert property (
    ce && acc && rgn == DNC_RGN_CTRL && !rd_nmi && s_r.nmi == 3'h0 &&
      !undefined_instr && !ext_fall |=> s_r.nmi == 3'h0)
    else $error("control access wrongly raised nmi");

  a_undef_set: assert property (
    ce && undefined_instr |=> s_r.nmi[`DNC_BIT_UND])
    else $error("undefined instruction bit not set");

  a_ext_fall: assert property (
    ce && $past(ce) && $fell(ext_nmi_b) |=> s_r.nmi[`DNC_BIT_EXT])
    else $error("external nmi edge not captured");

  a_nmi_req: assert property (
    nmi_req == (|s_r.nmi))
    else $error("nmi request does not follow status");

  a_nmi_rdclr: assert property (
    ce && rd_nmi && nmi_set == 3'h0 |=>
      s_r.nmi == 3'h0 && reg_rdata[2:0] == $past(s_r.nmi))
    else $error("nmi status read did not clear");

  a_rgn_ram: assert property (
    ce && acc && reg_addr[31:12] == 20'hfffe0 |=> dsp_region == DNC_RGN_RAM)
    else $error("internal ram region not decoded");

  a_rgn_dreg: assert property (
    ce && acc && reg_addr == `DNC_DREG_END |=> dsp_region == DNC_RGN_NONE)
    else $error("reserved region above registers decoded");

  a_rgn_ctrl: assert property (
    ce && acc && reg_addr[31:5] == 27'h7fffc80 |=>
      dsp_region == ((reg_addr[4:0] < 5'h14) ? DNC_RGN_CTRL : DNC_RGN_NONE))
    else $error("control region bound wrong");

  a_run_read: assert property (
    ce && reg_rd && ctrl_hit(reg_addr, `DNC_OFF_LIST_STAT) |=>
      reg_rdata == {15'h0000, $past(list_run)})
    else $error("run bit read wrong");

  a_resv_zero: assert property (
    reg_rdata[15:3] == 13'h0000)
    else $error("reserved read bits not zero");

  a_hold_write: assert property (
    ce && reg_wr && ctrl_hit(reg_addr, `DNC_OFF_EXT_HOLD) |=>
      ext_hold == $past(reg_wdata[`DNC_BIT_HOLD]))
    else $error("external hold write not stored");

  a_hold_read: assert property (
    ce && reg_rd && ctrl_hit(reg_addr, `DNC_OFF_EXT_HOLD) |=>
      reg_rdata == {15'h0000, $past(ext_hold)})
    else $error("external hold read wrong");

  a_mask_read: assert property (
    ce && reg_rd && ctrl_hit(reg_addr, `DNC_OFF_HALT_MASK) |=>
      reg_rdata == {15'h0000, $past(s_r.mask)})
    else $error("halt mask read wrong");

  a_halt_sticky: assert property (
    ce && s_r.halt && !rd_halt && !wr_abort |=> s_r.halt)
    else $error("halt status lost without read or abort");

  a_nmi_sticky: assert property (
    ce && !rd_nmi |=> (s_r.nmi & $past(s_r.nmi)) == $past(s_r.nmi))
    else $error("nmi status bit lost without read");

  a_nmi_clrreq: assert property (
    ce && rd_nmi && nmi_set == 3'h0 |=> !nmi_req)
    else $error("nmi request stayed after status read");

  a_busy_idle: assert property (
    ce && acc && !list_run && !undefined_instr && !ext_fall && !rd_nmi &&
      s_r.nmi == 3'h0 |=> s_r.nmi == 3'h0)
    else $error("idle access raised nmi");

  a_abort_pulse: assert property (
    list_abort |-> $past(wr_abort) || ($past(list_abort) && !$past(ce)))
    else $error("abort pulse without abort write");

  a_abort_irq: assert property (
    s_abort_write ##0 !halt_evt |=> !halt_irq_req)
    else $error("interrupt request survived abort");

  a_dreg_span: assert property (
    ce && acc && reg_addr[31:6] == 26'h3fffe00 && reg_addr[5:0] < 6'h28
      |=> dsp_region == DNC_RGN_DREG)
    else $error("dedicated register region not decoded");

  a_ram_top: assert property (
    ce && acc && reg_addr == `DNC_RAM_END |=> dsp_region == DNC_RGN_NONE)
    else $error("reserved region above ram decoded");

endmodule // dnc_core

`default_nettype wire

/* inc/dnc_params.svh */
`ifndef DNC_PARAMS_SVH
`define DNC_PARAMS_SVH

// Regions of the dsp_module in the core address map
`define DNC_RAM_BASE 32'hfffe0000
`define DNC_RAM_END 32'hfffe1000
`define DNC_DREG_BASE 32'hffff8000
`define DNC_DREG_END 32'hffff8028
`define DNC_CTRL_BASE 32'hffff9000
`define DNC_CTRL_END 32'hffff9014

// Byte offsets inside the control/status region
`define DNC_OFF_LIST_STAT 12'h000
`define DNC_OFF_EXT_HOLD 12'h004
`define DNC_OFF_HALT_STAT 12'h008
`define DNC_OFF_HALT_MASK 12'h00c
`define DNC_OFF_NMI_ABORT 12'h010

// Field positions
`define DNC_BIT_RUN 0
`define DNC_BIT_HOLD 0
`define DNC_BIT_HALT 0
`define DNC_BIT_EXT 0
`define DNC_BIT_UND 1
`define DNC_BIT_ERR 2

// Reset values
`define DNC_RST_REG16 16'h0000
`define DNC_RST_NMI 3'h0
`define DNC_RST_BIT 1'h0
`define DNC_RST_PIN 1'h1

`endif

/* inc/dnc_pkg.sv */
package dnc_pkg;

  typedef enum logic [1:0] {
    DNC_RGN_NONE,
    DNC_RGN_RAM,
    DNC_RGN_DREG,
    DNC_RGN_CTRL
  } dnc_region_t;

  typedef struct packed {
    logic halt;
    logic mask;
    logic [2:0] nmi;
    logic hold;
    logic run_d;
    logic [15:0] rdata;
    logic irq;
    logic nmi_req;
    logic abort;
    logic ovf_clr;
    dnc_region_t region;
  } dnc_state_t;

  typedef struct packed {
    logic prev;
  } dnc_edge_state_t;

endpackage

/* hdl/dnc_fall_det.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dnc_params.svh"

module dnc_fall_det
  import dnc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic pin_b,
  output logic fall
);

  dnc_edge_state_t s_r;
  dnc_edge_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = pin_b;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.prev <= `DNC_RST_PIN;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // High to low seen between two enabled samples
  assign fall = ce && s_r.prev && !pin_b;

endmodule // dnc_fall_det

`default_nettype wire

/* tb/dnc_list_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dnc_list_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic list_abort,
  output logic list_run
);
  logic [3:0] cnt_r;

  // Runs a fixed-length list; an abort stops it at once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (list_abort) begin
      cnt_r <= 4'h0;
    end else if (start) begin
      cnt_r <= 4'h8;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign list_run = (cnt_r != 4'h0);
endmodule // dnc_list_model

`default_nettype wire

/* tb/dsp_module_interrupt_nmi_control_test.sv */
`timescale 1ns/1ps
`default_nettype none

module dsp_module_interrupt_nmi_control_test;
  import dnc_pkg::*;
  localparam logic [31:0] A_RUN = 32'hffff9000;
  localparam logic [31:0] A_HOLD = 32'hffff9004;
  localparam logic [31:0] A_HST = 32'hffff9008;
  localparam logic [31:0] A_MSK = 32'hffff900c;
  localparam logic [31:0] A_NMI = 32'hffff9010;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic undefined_instr = 1'b0;
  logic ext_nmi_b = 1'b1;
  logic start = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic [15:0] reg_rdata, rd_v;
  logic halt_irq_req, nmi_req, list_abort, ovf_clear, ext_hold, list_run;
  dnc_region_t dsp_region, rg_v;
  int fails = 0;
  int n_checks = 0;

  dnc_core uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .list_run(list_run),
    .undefined_instr(undefined_instr), .ext_nmi_b(ext_nmi_b),
    .halt_irq_req(halt_irq_req), .nmi_req(nmi_req),
    .list_abort(list_abort), .ovf_clear(ovf_clear), .ext_hold(ext_hold),
    .dsp_region(dsp_region));
  dnc_list_model lm (.sys_clk(sys_clk), .rst_b(rst_b), .start(start),
    .list_abort(list_abort), .list_run(list_run));

  always #50 sys_clk = ~sys_clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
    rg_v = dsp_region;
  endtask

  task automatic pulse_start;
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 50 && list_run; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (list_run) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic t_reset;
    rd(A_HST);
    chk(rd_v, 16'h0000);
    rd(A_MSK);
    chk(rd_v, 16'h0000);
    rd(A_NMI);
    chk(rd_v, 16'h0000);
    chk({15'h0, nmi_req}, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_halt;
    wr(A_MSK, 16'hffff);
    rd(A_MSK);
    chk(rd_v, 16'h0001);
    pulse_start();
    rd(A_RUN);
    chk(rd_v, 16'h0001);
    chk({15'h0, nmi_req}, 16'h0000);
    wait_idle();
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0, halt_irq_req}, 16'h0001);
    rd(A_RUN);
    chk(rd_v, 16'h0000);
    rd(A_HST);
    chk(rd_v, 16'h0001);
    rd(A_HST);
    chk(rd_v, 16'h0000);
    chk({15'h0, halt_irq_req}, 16'h0000);
    wr(A_MSK, 16'h0000);
    $display("halt test done");
  endtask

  task automatic t_nmi;
    @(posedge sys_clk);
    undefined_instr <= 1'b1;
    @(posedge sys_clk);
    undefined_instr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({15'h0, nmi_req}, 16'h0001);
    rd(A_NMI);
    chk(rd_v, 16'h0002);
    rd(A_NMI);
    chk(rd_v, 16'h0000);
    chk({15'h0, nmi_req}, 16'h0000);
    @(posedge sys_clk);
    ext_nmi_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_nmi_b <= 1'b1;
    rd(A_NMI);
    chk(rd_v, 16'h0001);
    pulse_start();
    rd(32'hfffe0000);
    rd(A_NMI);
    chk(rd_v, 16'h0004);
    rd(32'hffff8000);
    rd(A_NMI);
    chk(rd_v, 16'h0004);
    wait_idle();
    rd(A_HST);
    chk(rd_v, 16'h0001);
    $display("nmi test done");
  endtask

  task automatic t_abort;
    wr(A_MSK, 16'h0001);
    wr(A_HOLD, 16'h0001);
    rd(A_HOLD);
    chk(rd_v, 16'h0001);
    pulse_start();
    wr(A_NMI, 16'h0000);
    chk({13'h0000, list_abort, ovf_clear, ext_hold}, 16'h0006);
    @(posedge sys_clk);
    #1;
    chk({15'h0, list_abort}, 16'h0000);
    rd(A_MSK);
    chk(rd_v, 16'h0000);
    chk({15'h0, list_run}, 16'h0000);
    rd(A_HST);
    chk(rd_v, 16'h0001);
    pulse_start();
    wait_idle();
    wr(A_NMI, 16'h1234);
    rd(A_HST);
    chk(rd_v, 16'h0000);
    $display("abort test done");
  endtask

  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    undefined_instr <= 1'b1;
    ext_nmi_b <= 1'b0;
    @(posedge sys_clk);
    undefined_instr <= 1'b0;
    ext_nmi_b <= 1'b1;
    @(posedge sys_clk);
    ce <= 1'b1;
    #1;
    chk({15'h0000, nmi_req}, 16'h0000);
    rd(A_NMI);
    chk(rd_v, 16'h0000);
    $display("freeze test done");
  endtask

  task automatic t_rst2;
    wr(A_MSK, 16'h0001);
    wr(A_HOLD, 16'h0001);
    @(posedge sys_clk);
    undefined_instr <= 1'b1;
    @(posedge sys_clk);
    undefined_instr <= 1'b0;
    #1;
    chk({14'h0000, nmi_req, ext_hold}, 16'h0003);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({13'h0000, nmi_req, ext_hold, halt_irq_req}, 16'h0000);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(A_MSK);
    chk(rd_v, 16'h0000);
    rd(A_NMI);
    chk(rd_v, 16'h0000);
    $display("second reset test done");
  endtask

  task automatic t_map;
    logic [31:0] at [9] = '{32'hfffe0000, 32'hfffe0ffc, 32'hfffe1000,
      32'hffff8000, 32'hffff8024, 32'hffff8028, 32'hffff9000,
      32'hffff9014, 32'h00001000};
    logic [1:0] ex [9] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h0,
      2'h0};
    for (int i = 0; i < 9; i++) begin
      rd(at[i]);
      chk({14'h0, rg_v}, {14'h0, ex[i]});
    end
    chk(rd_v, 16'h0000);
    $display("map test done");
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_halt();
    t_nmi();
    t_abort();
    t_map();
    t_freeze();
    t_rst2();
    stop_test();
  end
endmodule // dsp_module_interrupt_nmi_control_test

`default_nettype wire
